// *** repair_ctrl.sv ***
// Host sequencer for temporary and permanent row repair
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
module repair_ctrl
  import repair_pkg::*;
#(
  parameter int          DQ_W        = 8,
  parameter int unsigned NARROW_CYC  = PERM_NARROW_CYC,
  parameter int unsigned WIDE_CYC    = PERM_WIDE_CYC,
  parameter int unsigned POST_CYC    = PERM_POST_CYC
) (
  // Clock, reset, enable
  input  wire logic                  clk_in,
  input  wire logic                  rstn_in,
  input  wire logic                  ce_in,
  // Register port
  input  wire logic [7:0]            addr_in,
  input  wire logic [31:0]           wdata_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  output logic      [31:0]           rdata_out,
  // Capability bits read back from the device
  input  wire logic [1:0]            cap_in,
  // Memory command pins
  output repair_pkg::cmd_t           cmd_out,
  output logic      [1:0]            bg_out,
  output logic      [1:0]            ba_out,
  output logic      [repair_pkg::ROW_W-1:0] dev_addr_out,
  output logic      [DQ_W-1:0]       dq_out,
  output logic                       dq_oe_out,
  // Status
  output logic                       refresh_hold_out,
  output logic                       busy_out
);
  import repair_pkg::*;

  if (DQ_W < 1 || WIDE_CYC < NARROW_CYC || POST_CYC < 1) begin : g_chk
    $error("repair_ctrl: bad parameter values");
  end

  typedef struct packed {
    state_t           st;
    logic             issued;
    logic [1:0]       key_idx;
    logic             perm;
    logic             wide;
    logic             cancel;
    logic             dbi_ok;
    logic [1:0]       tgt_bg;
    logic [1:0]       tgt_ba;
    logic [ROW_W-1:0] tgt_row;
    logic [7:0]       tmod;
    logic [7:0]       trcd;
    logic [7:0]       wl;
    logic [7:0]       twr;
    logic [ROW_W-1:0] four_base;
    logic [ROW_W-1:0] zero_base;
    logic             done;
    logic             refused;
    logic [NUM_BG-1:0] perm_used;
    logic [NUM_BG-1:0] temp_act;
    cmd_t             cmd;
    logic [1:0]       bg;
    logic [1:0]       ba;
    logic [ROW_W-1:0] addr;
    logic [DQ_W-1:0]  dq;
    logic             dq_oe;
    logic             hold;
    logic             busy;
    logic [31:0]      rdata;
    logic [8:0]       gap;
  } regs_t;

  regs_t       r_reg;
  regs_t       r_next;
  logic [1:0]  cap_s;
  logic        tmr_done;
  logic        tmr_load;
  logic [31:0] tmr_val;
  logic        start;
  logic        refuse;

  repair_sync #(.W(2)) u_sync (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .ce_in   (ce_in),
    .d_in    (cap_in),
    .q_out   (cap_s)
  );

  repair_timer #(.W(32)) u_timer (
    .clk_in      (clk_in),
    .rstn_in     (rstn_in),
    .ce_in       (ce_in),
    .load_in     (tmr_load),
    .val_in      (tmr_val),
    .expired_out (tmr_done)
  );

  // Load value for N cycles between two command outputs
  // Wait and issue states cost one cycle each, so two at least
  function automatic logic [31:0] cyc(input logic [31:0] v);
    cyc = (v < 32'h2) ? 32'h0 : v - 32'h2;
  endfunction : cyc

  always_comb begin
    r_next       = r_reg;
    tmr_load     = 1'b0;
    tmr_val      = 32'h0;
    start        = 1'b0;
    refuse       = 1'b0;
    r_next.rdata = 32'h0;
    r_next.cmd   = CMD_DES;
    r_next.bg    = 2'h0;
    r_next.ba    = 2'h0;
    r_next.addr  = '0;
    r_next.gap   = (r_reg.cmd != CMD_DES) ? 9'h000 :
                   (r_reg.gap[8] ? r_reg.gap : r_reg.gap + 9'h001);

    if (rd_in) begin
      case (addr_in)
        OFF_CTRL: begin
          r_next.rdata[CTRL_PERM]   = r_reg.perm;
          r_next.rdata[CTRL_WIDE]   = r_reg.wide;
          r_next.rdata[CTRL_CANCEL] = r_reg.cancel;
          r_next.rdata[CTRL_DBI_OK] = r_reg.dbi_ok;
        end
        OFF_TARGET: begin
          r_next.rdata[1:0]                  = r_reg.tgt_bg;
          r_next.rdata[TGT_BA +: 2]          = r_reg.tgt_ba;
          r_next.rdata[TGT_ROW +: ROW_W]     = r_reg.tgt_row;
        end
        OFF_TIMING:
          r_next.rdata = {r_reg.twr, r_reg.wl, r_reg.trcd, r_reg.tmod};
        OFF_FOUR_BASE: r_next.rdata[ROW_W-1:0] = r_reg.four_base;
        OFF_ZERO_BASE: r_next.rdata[ROW_W-1:0] = r_reg.zero_base;
        OFF_STATUS: begin
          r_next.rdata[ST_BUSY]             = r_reg.busy;
          r_next.rdata[ST_DONE]             = r_reg.done;
          r_next.rdata[ST_REFUSED]          = r_reg.refused;
          r_next.rdata[ST_CAP +: 2]         = cap_s;
          r_next.rdata[ST_PERM_USED +: NUM_BG] = r_reg.perm_used;
          r_next.rdata[ST_TEMP_ACT +: NUM_BG]  = r_reg.temp_act;
        end
        default: r_next.rdata = 32'h0;
      endcase
    end

    // Configuration is frozen while a sequence runs
    if (wr_in && !r_reg.busy) begin
      case (addr_in)
        OFF_CTRL: begin
          r_next.perm   = wdata_in[CTRL_PERM];
          r_next.wide   = wdata_in[CTRL_WIDE];
          r_next.cancel = wdata_in[CTRL_CANCEL];
          r_next.dbi_ok = wdata_in[CTRL_DBI_OK];
          start         = wdata_in[CTRL_START];
          if (wdata_in[CTRL_CLR]) begin
            r_next.temp_act = '0; // [R6]
          end
        end
        OFF_TARGET: begin
          r_next.tgt_bg  = wdata_in[1:0];
          r_next.tgt_ba  = wdata_in[TGT_BA +: 2];
          r_next.tgt_row = wdata_in[TGT_ROW +: ROW_W];
        end
        OFF_TIMING: begin
          r_next.tmod = wdata_in[7:0];
          r_next.trcd = wdata_in[15:8];
          r_next.wl   = wdata_in[23:16];
          r_next.twr  = wdata_in[31:24];
        end
        OFF_FOUR_BASE: r_next.four_base = wdata_in[ROW_W-1:0];
        OFF_ZERO_BASE: r_next.zero_base = wdata_in[ROW_W-1:0];
        default: ;
      endcase
    end

    unique case (r_reg.st)
      S_IDLE: begin
        if (start) begin
          // Exhausted groups would be ignored silently by the device
          refuse = !r_next.dbi_ok ||                               // [R11]
                   r_next.perm_used[r_next.tgt_bg] ||              // [R4] [R9]
                   (r_next.perm ? (!cap_s[CAP_PERM] ||             // [R21]
                                   r_next.temp_act != '0)          // [R5]
                                : !cap_s[CAP_TEMP]);
          r_next.done    = 1'b0;
          r_next.refused = refuse;
          if (!refuse) begin
            r_next.st     = S_PREALL;
            r_next.busy   = 1'b1;
            r_next.issued = 1'b0;
          end
        end
      end
      S_PREALL: begin
        if (!r_reg.issued) begin
          r_next.cmd               = CMD_PRE;
          r_next.addr[PRE_ALL_BIT] = 1'b1; // [R11]
          tmr_load = 1'b1;
          tmr_val  = cyc({24'h0, r_reg.tmod});
          r_next.issued = 1'b1;
        end else if (tmr_done) begin
          r_next.st     = S_ENTRY;
          r_next.issued = 1'b0;
        end
      end
      S_ENTRY: begin
        if (!r_reg.issued) begin
          r_next.cmd                 = CMD_MRS;
          {r_next.bg[0], r_next.ba}  = FOUR_SEL;
          r_next.addr                = r_reg.four_base;
          r_next.addr[FOUR_TEMP_BIT] = !r_reg.perm; // [R7] [R12]
          r_next.addr[FOUR_PERM_BIT] = r_reg.perm;  // [R7]
          r_next.hold                = 1'b1;        // [R19]
          tmr_load = 1'b1;
          tmr_val  = cyc({24'h0, r_reg.tmod});      // [R12]
          r_next.issued = 1'b1;
        end else if (tmr_done) begin
          r_next.st      = S_KEY;
          r_next.key_idx = 2'h0;
          r_next.issued  = 1'b0;
        end
      end
      S_KEY: begin
        // Nothing may slip between key writes or the device aborts
        if (!r_reg.issued) begin
          r_next.cmd                      = CMD_MRS; // [R13] [R22]
          {r_next.bg[0], r_next.ba}       = ZERO_SEL;
          r_next.addr[KEY_HI_POS +: 5]    = KEY_HI[r_reg.key_idx];
          r_next.addr[6:0]                = KEY_LO;
          tmr_load = 1'b1;
          tmr_val  = cyc({24'h0, r_reg.tmod}); // [R13]
          r_next.issued = 1'b1;
        end else if (tmr_done) begin
          r_next.issued  = 1'b0;
          r_next.key_idx = r_reg.key_idx + 2'h1;
          if (r_reg.key_idx == 2'h3) begin
            r_next.st = S_ACT;
          end
        end
      end
      S_ACT: begin
        if (!r_reg.issued) begin
          r_next.cmd  = CMD_ACT; // [R14]
          r_next.bg   = r_reg.tgt_bg;
          r_next.ba   = r_reg.tgt_ba;
          r_next.addr = r_reg.tgt_row;
          tmr_load = 1'b1;
          tmr_val  = cyc({24'h0, r_reg.trcd}); // [R15]
          r_next.issued = 1'b1;
        end else if (tmr_done) begin
          r_next.st     = S_WRITE;
          r_next.issued = 1'b0;
        end
      end
      S_WRITE: begin
        if (!r_reg.issued) begin
          r_next.cmd = CMD_WR; // [R15]
          r_next.bg  = r_reg.tgt_bg;
          r_next.ba  = r_reg.tgt_ba;
          tmr_load = 1'b1;
          tmr_val  = cyc({24'h0, r_reg.wl}); // [R16]
          r_next.issued = 1'b1;
        end else if (tmr_done) begin
          r_next.st     = S_DATA;
          r_next.issued = 1'b0;
        end
      end
      S_DATA: begin
        // Cancel pattern is held for all four beats, beyond two
        if (!r_reg.issued) begin
          r_next.dq    = r_reg.cancel ? '1 : '0; // [R16]
          r_next.dq_oe = 1'b1;
          tmr_load = 1'b1;
          tmr_val  = 32'(DATA_BEATS - 1);         // [R16]
          r_next.issued = 1'b1;
        end else if (tmr_done) begin
          r_next.dq_oe  = 1'b0;
          r_next.dq     = '0;
          r_next.st     = S_RECOV;
          r_next.issued = 1'b0;
        end
      end
      S_RECOV: begin
        if (!r_reg.issued) begin
          tmr_load = 1'b1;
          if (r_reg.perm) begin
            tmr_val = r_reg.wide ? WIDE_CYC : NARROW_CYC; // [R1]
          end else begin
            tmr_val = cyc({24'h0, r_reg.twr}); // [R3] [R17]
          end
          r_next.issued = 1'b1;
        end else if (tmr_done) begin
          r_next.st     = S_PRE;
          r_next.issued = 1'b0;
        end
      end
      S_PRE: begin
        if (!r_reg.issued) begin
          r_next.cmd = CMD_PRE; // [R17]
          r_next.bg  = r_reg.tgt_bg;
          r_next.ba  = r_reg.tgt_ba;
          tmr_load = 1'b1;
          tmr_val  = r_reg.perm ? cyc(PERM_SETTLE_CYC)  // [R2]
                                : cyc(TEMP_SETTLE_CYC); // [R17]
          r_next.issued = 1'b1;
        end else if (tmr_done) begin
          r_next.st     = S_EXIT;
          r_next.issued = 1'b0;
        end
      end
      S_EXIT: begin
        if (!r_reg.issued) begin
          r_next.cmd                = CMD_MRS; // [R8] [R18]
          {r_next.bg[0], r_next.ba}  = FOUR_SEL;
          r_next.addr                = r_reg.four_base;
          r_next.addr[FOUR_TEMP_BIT] = 1'b0;
          r_next.addr[FOUR_PERM_BIT] = 1'b0;
          r_next.hold               = 1'b0; // [R19]
          tmr_load = 1'b1;
          tmr_val  = r_reg.perm ? cyc(POST_CYC)                // [R2]
                                : cyc({24'h0, r_reg.tmod});    // [R18]
          r_next.issued = 1'b1;
        end else if (tmr_done) begin
          r_next.st     = S_RESTORE;
          r_next.issued = 1'b0;
        end
      end
      S_RESTORE: begin
        if (!r_reg.issued) begin
          r_next.cmd                = CMD_MRS;
          {r_next.bg[0], r_next.ba} = ZERO_SEL;
          r_next.addr               = r_reg.zero_base;
          tmr_load = 1'b1;
          tmr_val  = cyc({24'h0, r_reg.tmod});
          r_next.issued = 1'b1;
        end else if (tmr_done) begin
          r_next.st     = S_IDLE;
          r_next.issued = 1'b0;
          r_next.busy   = 1'b0;
          r_next.done   = 1'b1;
          // A cancelled run leaves the device records untouched
          if (!r_reg.cancel) begin
            if (r_reg.perm) begin
              r_next.perm_used[r_reg.tgt_bg] = 1'b1; // [R23]
            end else begin
              r_next.temp_act[r_reg.tgt_bg] = 1'b1;  // [R20] [R23]
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r_reg      <= '0;
      r_reg.st   <= S_IDLE;
      r_reg.cmd  <= CMD_DES;
      r_reg.tmod <= TMOD_RST;
      r_reg.trcd <= TRCD_RST;
      r_reg.wl   <= WL_RST;
      r_reg.twr  <= TWR_RST;
    end else if (ce_in) begin
      r_reg <= r_next;
    end
  end

  assign rdata_out        = r_reg.rdata;
  assign cmd_out          = r_reg.cmd;
  assign bg_out           = r_reg.bg;
  assign ba_out           = r_reg.ba;
  assign dev_addr_out     = r_reg.addr;
  assign dq_out           = r_reg.dq;
  assign dq_oe_out        = r_reg.dq_oe;
  assign refresh_hold_out = r_reg.hold;
  assign busy_out         = r_reg.busy;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in || !ce_in);

  a_key_spacing: assert property ( // [R13]
    cmd_out == CMD_MRS && r_reg.st == S_KEY
    |-> r_reg.gap + 9'h001 >= {1'b0, r_reg.tmod}
        && bg_out == 2'h0 && ba_out == 2'h0)
    else $error("guard key write too early or wrong select");
  a_key_value: assert property ( // [R13]
    cmd_out == CMD_MRS && r_reg.st == S_KEY
    |-> dev_addr_out[6:0] == KEY_LO
        && dev_addr_out[11:7] == KEY_HI[r_reg.key_idx])
    else $error("guard key value wrong");
  a_entry_bits: assert property ( // [R7] [R12]
    cmd_out == CMD_MRS && r_reg.st == S_ENTRY
    |-> dev_addr_out[FOUR_TEMP_BIT] != r_reg.perm
        && dev_addr_out[FOUR_PERM_BIT] == r_reg.perm && refresh_hold_out)
    else $error("mode four entry bits wrong");
  a_exit_bits: assert property ( // [R18]
    cmd_out == CMD_MRS && r_reg.st == S_EXIT
    |-> !dev_addr_out[FOUR_TEMP_BIT] && !dev_addr_out[FOUR_PERM_BIT]
        && !refresh_hold_out)
    else $error("mode four exit bits not cleared");
  a_hold_span: assert property ( // [R19]
    r_reg.st inside {S_KEY, S_ACT, S_WRITE, S_DATA, S_RECOV, S_PRE}
    |-> refresh_hold_out)
    else $error("refresh hold dropped inside repair");
  a_act_seed: assert property ( // [R14]
    cmd_out == CMD_ACT |-> bg_out == r_reg.tgt_bg
      && ba_out == r_reg.tgt_ba && dev_addr_out == r_reg.tgt_row)
    else $error("activate does not carry seed row");
  a_rcd_gap: assert property ( // [R15]
    cmd_out == CMD_WR |-> r_reg.gap + 9'h001 >= {1'b0, r_reg.trcd})
    else $error("write issued before row-to-column delay");
  a_data_beats: assert property ( // [R16]
    $rose(dq_oe_out) |-> dq_oe_out [*4] ##1 !dq_oe_out)
    else $error("data window not four cycles");
  a_data_level: assert property ( // [R16]
    dq_oe_out |-> dq_out == (r_reg.cancel ? {DQ_W{1'b1}} : {DQ_W{1'b0}}))
    else $error("data pattern wrong");
  a_settle_gap: assert property ( // [R17]
    cmd_out == CMD_MRS && r_reg.st == S_EXIT && !r_reg.perm
    |-> r_reg.gap + 9'h001 >= 9'(TEMP_SETTLE_CYC))
    else $error("exit too soon after precharge");
  a_perm_refuse: assert property ( // [R5]
    wr_in && addr_in == OFF_CTRL && wdata_in[CTRL_START]
    && wdata_in[CTRL_PERM] && r_reg.temp_act != '0 && !busy_out
    |=> !busy_out && r_reg.refused)
    else $error("permanent repair not refused");

  c_temp_done: cover property (
    r_reg.st == S_RESTORE && tmr_done && !r_reg.perm && !r_reg.cancel);
  c_perm_start: cover property (r_reg.st == S_ENTRY && r_reg.perm);
  c_cancel: cover property ($rose(dq_oe_out) && r_reg.cancel);
endmodule : repair_ctrl

// *** repair_pkg.sv ***
// Constants and types for the row-repair sequencer
// Functional notes
// [R1] Permanent program wait 1000 ms, 2000 ms wide
// [R2] Permanent: 15 ns after precharge, 50 us after exit
// [R3] Temporary program interval is WL plus 4 plus tWR
// [R4] One repair element per bank group
// [R5] No permanent repair while temporary repairs outstanding
// [R6] Reset or power loss undoes temporary repairs
// [R7] Mode four bit 5 temporary, bit 13 permanent
// [R8] Always exit the last repair mode first
// [R9] Device ignores repair to exhausted bank group
// [R10] Seed row neighbours lose their data
// [R11] Banks precharged, inversion and CRC off first
// [R12] Entry write of mode four, then wait tMOD
// [R13] Four guard key writes, tMOD apart, fixed fields
// [R14] Activate carries failing bank and row
// [R15] Write after tRCD, column address ignored
// [R16] Data low four beats selects, high cancels
// [R17] Wait tWR, precharge, then wait 20 ns
// [R18] Exit clears bit 5, then wait tMOD
// [R19] No refresh between entry and exit
// [R20] Newer temporary repair replaces older in group
// [R21] Capability bits: permanent bit 7, temporary bit 6
// [R22] Broken guard key aborts silently, no lockup
// [R23] Per-group records of used and active repairs
package repair_pkg;
  localparam int          CLK_MHZ         = 100;
  localparam int          ROW_W           = 18;
  localparam int          NUM_BG          = 4;
  localparam logic [7:0]  OFF_CTRL        = 8'h00;
  localparam logic [7:0]  OFF_TARGET      = 8'h04;
  localparam logic [7:0]  OFF_TIMING      = 8'h08;
  localparam logic [7:0]  OFF_FOUR_BASE   = 8'h0c;
  localparam logic [7:0]  OFF_ZERO_BASE   = 8'h10;
  localparam logic [7:0]  OFF_STATUS      = 8'h14;
  localparam int          CTRL_START      = 0;
  localparam int          CTRL_PERM       = 1;
  localparam int          CTRL_WIDE       = 2;
  localparam int          CTRL_CANCEL     = 3;
  localparam int          CTRL_DBI_OK     = 4;
  localparam int          CTRL_CLR        = 5;
  localparam int          TGT_BA          = 2;
  localparam int          TGT_ROW         = 4;
  localparam int          ST_BUSY         = 0;
  localparam int          ST_DONE         = 1;
  localparam int          ST_REFUSED      = 2;
  localparam int          ST_CAP          = 3;
  localparam int          ST_PERM_USED    = 8;
  localparam int          ST_TEMP_ACT     = 12;
  localparam int          CAP_TEMP        = 0;
  localparam int          CAP_PERM        = 1;
  localparam logic [7:0]  TMOD_RST        = 8'h18;
  localparam logic [7:0]  TRCD_RST        = 8'h16;
  localparam logic [7:0]  WL_RST          = 8'h14;
  localparam logic [7:0]  TWR_RST         = 8'h18;
  localparam int          FOUR_TEMP_BIT   = 5;
  localparam int          FOUR_PERM_BIT   = 13;
  localparam int          PRE_ALL_BIT     = 10;
  localparam logic [2:0]  FOUR_SEL        = 3'h4;
  localparam logic [2:0]  ZERO_SEL        = 3'h0;
  localparam int          KEY_HI_POS      = 7;
  localparam logic [6:0]  KEY_LO          = 7'h7f;
  localparam logic [4:0]  KEY_HI [4]      = '{5'h19, 5'h0f, 5'h17, 5'h07};
  localparam int          DATA_BEATS      = 4;
  localparam int          TEMP_SETTLE_NS  = 20;
  localparam int          PERM_SETTLE_NS  = 15;
  localparam int          PERM_POST_US    = 50;
  localparam int          PERM_NARROW_MS  = 1000;
  localparam int          PERM_WIDE_MS    = 2000;
  localparam int          TEMP_SETTLE_CYC = (TEMP_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int          PERM_SETTLE_CYC = (PERM_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int          PERM_POST_CYC   = PERM_POST_US * CLK_MHZ;
  localparam int          PERM_NARROW_CYC = PERM_NARROW_MS * CLK_MHZ * 1000;
  localparam int          PERM_WIDE_CYC   = PERM_WIDE_MS * CLK_MHZ * 1000;

  typedef enum logic [2:0] {
    CMD_DES, CMD_MRS, CMD_ACT, CMD_WR, CMD_PRE
  } cmd_t;

  typedef enum logic [3:0] {
    S_IDLE, S_PREALL, S_ENTRY, S_KEY, S_ACT, S_WRITE, S_DATA,
    S_RECOV, S_PRE, S_EXIT, S_RESTORE
  } state_t;
endpackage : repair_pkg

// *** repair_sync.sv ***
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module repair_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic         ce_in,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_t;
  sync_t r_reg;
  sync_t r_next;

  always_comb begin
    r_next    = r_reg;
    r_next.s1 = d_in;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (r_reg.s2[i] == r_reg.s3[i]) begin
        r_next.q[i] = r_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r_reg <= '0;
    end else if (ce_in) begin
      r_reg <= r_next;
    end
  end

  assign q_out = r_reg.q;
endmodule : repair_sync

// *** repair_timer.sv ***
// Loadable down-counter used for every command spacing
`timescale 1ns/1ps
module repair_timer #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic         ce_in,
  // Control
  input  wire logic         load_in,
  input  wire logic [W-1:0] val_in,
  output logic              expired_out
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } tmr_t;
  tmr_t r_reg;
  tmr_t r_next;

  always_comb begin
    r_next = r_reg;
    if (load_in) begin
      r_next.cnt = val_in;
    end else if (r_reg.cnt != '0) begin
      r_next.cnt = r_reg.cnt - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r_reg <= '0;
    end else if (ce_in) begin
      r_reg <= r_next;
    end
  end

  assign expired_out = (r_reg.cnt == '0);
endmodule : repair_timer

// *** repair_dev.sv ***
// Behavioural memory device answering the repair command sequence
`timescale 1ns/1ps
module repair_dev
  import repair_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire cmd_t             cmd_in,
  input  wire logic [1:0]       bg_in,
  input  wire logic [1:0]       ba_in,
  input  wire logic [17:0]      a_in,
  input  wire logic [7:0]       dq_in,
  input  wire logic             oe_in,
  output logic      [1:0]       cap_out,
  output logic      [3:0]       used_out,
  output logic      [3:0]       tmp_out,
  output logic      [3:0][19:0] seed_out
);
  int         key;
  int         low;
  logic       perm;
  logic [1:0] sbg;
  logic [19:0] srow;
  assign cap_out = 2'h3;
  // Permanent records survive reset
  initial used_out = '0;
  always @(posedge clk_in or negedge rstn_in)
    if (!rstn_in) begin
      key <= 0;
      low <= 0;
      tmp_out <= '0;
    end else if (key == 7 && low == 4) begin
      key <= 0;
      if (!used_out[sbg]) begin
        if (perm) used_out[sbg] <= 1'b1;
        else begin
          tmp_out[sbg] <= 1'b1;
          seed_out[sbg] <= srow;
        end
      end
    end else if (key == 7 && oe_in) begin
      if (dq_in == '0) low <= low + 1;
      else key <= 0;
    end else case (cmd_in)
      CMD_MRS: if ({bg_in[0], ba_in} == FOUR_SEL && (a_in[5] | a_in[13])) begin
          key <= 1;
          low <= 0;
          perm <= a_in[13];
        end else if ({bg_in, ba_in} == 4'h0 && key > 0 && key < 5
                     && a_in[11:0] == {KEY_HI[key-1], KEY_LO}) key <= key + 1;
        else key <= 0;
      CMD_ACT: if (key == 5) begin
          sbg <= bg_in;
          // Neighbour rows of the seed lose data; no array is modelled
          srow <= {ba_in, a_in};
          key <= 6;
        end else key <= 0;
      CMD_WR:  key <= (key == 6) ? 7 : 0;
      CMD_DES: ;
      default: key <= 0;
    endcase
endmodule : repair_dev

// *** post_package_row_repair_tb.sv ***
// Self-checking bench for the row-repair sequencer
`timescale 1ns/1ps
module post_package_row_repair_tb;
  import repair_pkg::*;
  logic clk_in = 0, rstn_in = 0, ce_in = 1, wr_in = 0, rd_in = 0;
  logic [7:0] addr_in = '0;
  logic [31:0] wdata_in = '0, rdata_out, r;
  logic [1:0] cap, bg, ba;
  logic [17:0] da;
  logic [7:0] dq;
  logic oe, hold, busy_out;
  logic [3:0] used, tmp;
  logic [3:0][19:0] seed;
  cmd_t cmd;
  int bad_count = 0, checks_done = 0, gap, lat = 0, hw;
  time t_act;
  always #5 clk_in = ~clk_in;
  repair_ctrl #(.NARROW_CYC(20), .WIDE_CYC(40), .POST_CYC(10)) repair_ctrl_inst (
    .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .cap_in(cap), .cmd_out(cmd), .bg_out(bg),
    .ba_out(ba), .dev_addr_out(da), .dq_out(dq), .dq_oe_out(oe),
    .refresh_hold_out(hold), .busy_out(busy_out));
  repair_dev repair_dev_inst (.clk_in(clk_in), .rstn_in(rstn_in),
    .cmd_in(cmd), .bg_in(bg), .ba_in(ba), .a_in(da), .dq_in(dq),
    .oe_in(oe), .cap_out(cap), .used_out(used), .tmp_out(tmp),
    .seed_out(seed));
  // ACT to WR and WR to first data beat spacing seen on the pins
  always @(posedge clk_in)
    if (cmd === CMD_ACT) t_act = $time;
    else if (cmd === CMD_WR) begin
      gap = ($time - t_act) / 10;
      t_act = $time;
      hw = hold;
    end else if (oe === 1'b1 && lat == 0) lat = ($time - t_act) / 10;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
    @(posedge clk_in) wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    addr_in <= a; rd_in <= 1'b1;
    @(posedge clk_in) rd_in <= 1'b0;
    #1 d = rdata_out;
    @(posedge clk_in);
  endtask : rreg
  task automatic do_reset();
    rstn_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
  endtask : do_reset
  // Start a sequence, wait it out, compare the status word
  task automatic run(input logic [31:0] ctl, input logic [31:0] st);
    wreg(OFF_CTRL, ctl);
    for (int n = 0; n < 3000 && busy_out !== 1'b0; n++) @(posedge clk_in);
    rreg(OFF_STATUS, r);
    chk(r, st);
  endtask : run
  task automatic complete_run();
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  initial begin
    #300000;
    bad_count++;
    complete_run();
  end
  initial begin
    do_reset();
    repeat (4) @(posedge clk_in);
    rreg(OFF_STATUS, r); chk(r, 32'h18);
    rreg(OFF_TIMING, r); chk(r, 32'h18141618);
    rreg(8'h18, r); chk(r, 32'h0);
    run(32'h01, 32'h1c);
    wreg(OFF_TARGET, {10'h0, 18'h2a5c3, 2'h1, 2'h2});
    run(32'h11, 32'h401a);
    chk({tmp, seed[2]}, {4'h4, 2'h1, 18'h2a5c3});
    chk(gap, 32'd22);
    chk(lat, 32'd20);
    chk(hw, 32'd1);
    wreg(OFF_TARGET, {10'h0, 18'h01234, 2'h3, 2'h2});
    run(32'h11, 32'h401a);
    chk(seed[2], {2'h3, 18'h01234});
    wreg(OFF_TARGET, 32'h5);
    run(32'h19, 32'h401a);
    chk(tmp, 4'h4);
    run(32'h13, 32'h401c);
    do_reset();
    chk(tmp, 4'h0);
    wreg(OFF_CTRL, 32'h20);
    wreg(OFF_TARGET, 32'h2);
    run(32'h13, 32'h41a);
    chk(used, 4'h4);
    run(32'h11, 32'h41c);
    complete_run();
  end
endmodule : post_package_row_repair_tb
